/* File: casc_timer_params.svh */
// Constants for the cascaded 16-bit timer counter
`ifndef CASC_TIMER_PARAMS_SVH
`define CASC_TIMER_PARAMS_SVH
`define CLKSEL_FX       3'h0
`define CLKSEL_FX_DIV2  3'h1
`define CLKSEL_EXT      3'h2
`define CLKSEL_EXT_DIV2 3'h3
`define CLKSEL_EXT_DIV4 3'h4
`define CLKSEL_EXT_DIV8 3'h5
`define COUNT_RESET     8'h00
`define COUNT_MAX       8'hFF
`define PRE_RESET       3'h0
`endif

/* File: casc_timer_pkg.sv */
// Types for the cascaded 16-bit timer counter
package casc_timer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] clk_sel_t;
endpackage : casc_timer_pkg

/* File: cascaded_16bit_timer_counter.sv */
// Cascaded 16-bit timer counter built from two 8-bit halves
//
// Behaviour
// - Upper half high byte, lower half low
// - Only lower enable starts, stops, clears
// - Joint match clears both, counting continues
// - Match raises lower interrupt only
// - Three-bit select chooses the count clock
// - Event mode counts each rising external edge
// - Square wave toggles on each joint match
// - Enable low forces square wave low
// - Enabled output starts low
// - First match may be one clock early
`timescale 1ns/1ps
`include "casc_timer_params.svh"
module cascaded_16bit_timer_counter (
   input  wire logic                     core_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     lower_count_enable_i,
   input  wire logic                     upper_count_enable_i,
   input  wire casc_timer_pkg::clk_sel_t clock_select_i,
   input  wire casc_timer_pkg::byte_t    upper_compare_reg_i,
   input  wire casc_timer_pkg::byte_t    lower_compare_reg_i,
   input  wire logic                     lower_output_enable_a_i,
   input  wire logic                     lower_output_enable_b_i,
   input  wire logic                     external_count_input_i,
   output logic [7:0]                    upper_count_reg_o,
   output logic [7:0]                    lower_count_reg_o,
   output logic                          lower_match_irq_o,
   output logic                          upper_match_irq_o,
   output logic                          lower_timer_out_pin_a_o,
   output logic                          lower_timer_out_pin_b_o
);
   import casc_timer_pkg::*;

   byte_t    upper_q, upper_d, lower_q, lower_d;
   logic     ext_q, ext_d, div2_q, div2_d, wave_q, wave_d;
   logic     irq_q, irq_d, out_a_q, out_a_d, out_b_q, out_b_d;
   // Upper interrupt is a flop held low so every output is registered
   logic     upper_irq_q, upper_irq_d;
   clk_sel_t pre_q, pre_d;
   logic     tick, edge_ext, match;

   // Upper enable is ignored: the pair is governed by the lower half
   logic unused_en;
   assign unused_en = upper_count_enable_i;

   always_comb begin
      // Pin is taken as synchronous, so one flop finds its rising edge
      ext_d    = external_count_input_i;
      edge_ext = external_count_input_i & ~ext_q;
      div2_d   = lower_count_enable_i ? ~div2_q : 1'b0;
      pre_d    = pre_q;
      if (!lower_count_enable_i) begin
         pre_d = `PRE_RESET;
      end else if (edge_ext) begin
         pre_d = clk_sel_t'(pre_q + 3'h1);
      end
      tick = 1'b0;
      case (clock_select_i)
         `CLKSEL_FX:       tick = 1'b1;
         `CLKSEL_FX_DIV2:  tick = div2_q;
         `CLKSEL_EXT:      tick = edge_ext;
         `CLKSEL_EXT_DIV2: tick = edge_ext & pre_q[0];
         `CLKSEL_EXT_DIV4: tick = edge_ext & (pre_q[1:0] == 2'h3);
         `CLKSEL_EXT_DIV8: tick = edge_ext & (pre_q == 3'h7);
         default:          tick = 1'b0;
      endcase
      // Prescaler restarts with enable, so first period may be short
      tick  = tick & lower_count_enable_i;
      match = (upper_q == upper_compare_reg_i) &&
              (lower_q == lower_compare_reg_i);
      upper_d = upper_q;
      lower_d = lower_q;
      wave_d  = wave_q;
      irq_d   = 1'b0;
      upper_irq_d = 1'b0;
      if (!lower_count_enable_i) begin
         upper_d = `COUNT_RESET;
         lower_d = `COUNT_RESET;
         wave_d  = 1'b0;
      end else if (tick) begin
         if (match) begin
            upper_d = `COUNT_RESET;
            lower_d = `COUNT_RESET;
            irq_d   = 1'b1;
            wave_d  = ~wave_q;
         end else begin
            lower_d = byte_t'(lower_q + 8'h01);
            if (lower_q == `COUNT_MAX) begin
               upper_d = byte_t'(upper_q + 8'h01);
            end
         end
      end
      // Pins take the new wave level, so they change with the counters
      out_a_d = lower_output_enable_a_i & wave_d;
      out_b_d = lower_output_enable_b_i & wave_d;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         upper_q <= `COUNT_RESET;
         lower_q <= `COUNT_RESET;
         ext_q   <= 1'b0;
         div2_q  <= 1'b0;
         pre_q   <= `PRE_RESET;
         wave_q  <= 1'b0;
         irq_q   <= 1'b0;
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         upper_irq_q <= 1'b0;
      end else begin
         upper_q <= upper_d;
         lower_q <= lower_d;
         ext_q   <= ext_d;
         div2_q  <= div2_d;
         pre_q   <= pre_d;
         wave_q  <= wave_d;
         irq_q   <= irq_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         upper_irq_q <= upper_irq_d;
      end
   end

   assign upper_count_reg_o       = upper_q;
   assign lower_count_reg_o       = lower_q;
   assign lower_match_irq_o       = irq_q;
   assign upper_match_irq_o       = upper_irq_q;
   assign lower_timer_out_pin_a_o = out_a_q;
   assign lower_timer_out_pin_b_o = out_b_q;

   // Flat tick count since the last clear, kept apart from the two byte
   // counters so that carry and byte order are checked independently
   logic [16:0] cyc_q, cyc_d;
   always_comb begin
      cyc_d = cyc_q;
      if (!lower_count_enable_i || (tick && match)) begin
         cyc_d = 17'h0_0000;
      end else if (tick) begin
         cyc_d = 17'(cyc_q + 17'h0_0001);
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         cyc_q <= 17'h0_0000;
      end else begin
         cyc_q <= cyc_d;
      end
   end

   no_upper_irq_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) !upper_match_irq_o)
      else $error("upper interrupt raised");
   stop_clears_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) !lower_count_enable_i |=>
      upper_q == 8'h00 && lower_q == 8'h00)
      else $error("stop did not clear counters");
   stop_wave_low_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) !lower_count_enable_i |=>
      !lower_timer_out_pin_a_o && !lower_timer_out_pin_b_o)
      else $error("wave not low when stopped");
   match_clear_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) lower_count_enable_i && tick && match |=>
      irq_q && upper_q == 8'h00 && lower_q == 8'h00)
      else $error("match did not clear");
   carry_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) lower_count_enable_i && tick && !match &&
      lower_q == 8'hFF |=> lower_q == 8'h00 &&
      upper_q == $past(upper_q) + 8'h01)
      else $error("carry lost");
   wave_toggle_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) $rose(irq_q) && $past(lower_count_enable_i)
      |-> wave_q != $past(wave_q))
      else $error("wave did not toggle");
   fx_count_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) clock_select_i == 3'h0 &&
      lower_count_enable_i && !match |=>
      lower_q == $past(lower_q) + 8'h01)
      else $error("fx did not count");
   period_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) lower_count_enable_i && tick && match |->
      cyc_q == {1'b0, upper_compare_reg_i, lower_compare_reg_i})
      else $error("period differs from compare plus one");
   ext_idle_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) clock_select_i == 3'h2 &&
      !(external_count_input_i && !ext_q) |=> $stable(lower_q) ||
      lower_q == 8'h00)
      else $error("counted without edge");
   ext_count_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) clock_select_i == `CLKSEL_EXT &&
      lower_count_enable_i && edge_ext && !match |=>
      lower_q == $past(lower_q) + 8'h01)
      else $error("edge not counted");
   half_rate_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) clock_select_i == `CLKSEL_FX_DIV2 &&
      lower_count_enable_i && !div2_q |=> $stable(lower_q))
      else $error("half rate counted early");
   irq_cause_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) irq_q |->
      $past(lower_count_enable_i && tick && match))
      else $error("interrupt without match");
   start_low_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) $rose(lower_count_enable_i) |->
      !lower_timer_out_pin_a_o && !lower_timer_out_pin_b_o)
      else $error("pin not low at start");
   pin_a_follow_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) 1'b1 |=>
      lower_timer_out_pin_a_o == ($past(lower_output_enable_a_i) && wave_q))
      else $error("pin a does not follow wave");
   pin_b_follow_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i) 1'b1 |=>
      lower_timer_out_pin_b_o == ($past(lower_output_enable_b_i) && wave_q))
      else $error("pin b does not follow wave");
endmodule : cascaded_16bit_timer_counter

/* File: evt_src.sv */
// External pulse source feeding the timer count input pin
`timescale 1ns/1ps
module evt_src #(
   parameter int GAP = 4
) (
   input  wire logic clk_i,
   input  wire logic run_i,
   output logic      pulse_o
);
   int cnt_q = 0;
   // One-cycle pulses, launched after the edge like a real source
   always_ff @(posedge clk_i) begin
      cnt_q   <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      pulse_o <= run_i && (cnt_q == 0);
   end
endmodule : evt_src

/* File: tb_cascaded_16bit_timer_counter.sv */
// Self-checking bench for the cascaded 16-bit timer counter
`timescale 1ns/1ps
module tb_cascaded_16bit_timer_counter;
   import casc_timer_pkg::*;
   typedef struct {clk_sel_t s; byte_t h; byte_t l; int per;} row_s;
   logic       clk = 1'b0, rst = 1'b1, en = 1'b0, up_en = 1'b0;
   logic       oe_a = 1'b0, oe_b = 1'b0, evt, irq_lo, irq_hi, pa, pb, w0;
   clk_sel_t   sel = 3'h0;
   byte_t      ch = 8'h00, cl = 8'h00;
   logic [7:0] hi, lo;
   int         fail_count = 0, cmp_count = 0, cyc = 0, p;
   // Period in core cycles; source pulses every 4 cycles
   row_s rows[7] = '{'{3'h0, 8'h00, 8'h03, 4}, '{3'h1, 8'h00, 8'h03, 8},
      '{3'h0, 8'h01, 8'h00, 257}, '{3'h2, 8'h00, 8'h02, 12},
      '{3'h3, 8'h00, 8'h02, 24}, '{3'h4, 8'h00, 8'h02, 48},
      '{3'h5, 8'h00, 8'h01, 64}};
   always #50 clk = ~clk;
   evt_src src_u (.clk_i(clk), .run_i(1'b1), .pulse_o(evt));
   cascaded_16bit_timer_counter dut_u (.core_clk_i(clk), .reset_i(rst),
      .lower_count_enable_i(en), .upper_count_enable_i(up_en),
      .clock_select_i(sel), .upper_compare_reg_i(ch),
      .lower_compare_reg_i(cl), .lower_output_enable_a_i(oe_a),
      .lower_output_enable_b_i(oe_b), .external_count_input_i(evt),
      .upper_count_reg_o(hi), .lower_count_reg_o(lo),
      .lower_match_irq_o(irq_lo), .upper_match_irq_o(irq_hi),
      .lower_timer_out_pin_a_o(pa), .lower_timer_out_pin_b_o(pb));
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq_lo !== 1'b1 && n < 3000);
   endtask : wait_irq
   task automatic stop_test();
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   // Ceiling far above the thousand or so cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      up_en <= 1'b1;
      repeat (2) @(negedge clk);
      check("outs", {hi, lo, irq_lo, irq_hi, pa, pb}, 0);
      repeat (10) @(negedge clk);
      check("upper_en", {hi, lo}, 0);
      foreach (rows[i]) begin
         @(posedge clk);
         en <= 1'b0;
         @(posedge clk);
         sel <= rows[i].s;
         ch <= rows[i].h;
         cl <= rows[i].l;
         oe_a <= 1'b1;
         @(posedge clk);
         en <= 1'b1;
         wait_irq(p);
         w0 = pa;
         check("clear", {hi, lo}, 0);
         wait_irq(p);
         check("period", p, rows[i].per);
         check("irq_hi", irq_hi, 0);
         check("wave", {w0, pa}, 2'b10);
         check("pin_b", pb, 0);
      end
      @(posedge clk);
      en <= 1'b0;
      @(posedge clk);
      oe_a <= 1'b0;
      oe_b <= 1'b1;
      sel <= 3'h0;
      cl <= 8'h03;
      @(posedge clk);
      en <= 1'b1;
      @(negedge clk);
      check("first", pb, 0);
      wait_irq(p);
      check("toggle", {pa, pb}, 2'b01);
      @(posedge clk);
      en <= 1'b0;
      repeat (2) @(negedge clk);
      check("stop", {hi, lo, pa, pb}, 0);
      stop_test();
   end
endmodule : tb_cascaded_16bit_timer_counter
